// file: core/swc_sleep_wakeup_control.sv
// Power-down entry, wake-up sequencing and watchdog for the core
module swc_sleep_wakeup_control #(
    parameter int unsigned WDT_CYCLES = swc_pkg::WDT_CYCLES_DEF,
    parameter int          PCW        = swc_pkg::PC_W
) (
    // Clock and reset
    input  wire logic                        core_clk,
    input  wire logic                        rst_n,
    // Avalon-MM slave
    input  wire logic [swc_pkg::ADDR_W-1:0]  avs_address,
    input  wire logic                        avs_read,
    input  wire logic                        avs_write,
    input  wire logic [swc_pkg::DATA_W-1:0]  avs_writedata,
    output logic      [swc_pkg::DATA_W-1:0]  avs_readdata,
    output logic                             avs_waitrequest,
    // Pins
    input  wire logic                        external_reset_pin_n,
    input  wire logic                        edge_irq_pin,
    // Peripheral events, core clock domain
    input  wire logic                        port_change,
    input  wire logic                        comparator_irq,
    // Core side
    input  wire logic                        sleep_exec,
    input  wire logic                        clrwdt,
    input  wire logic [PCW-1:0]              cur_pc,
    output logic                             core_hold,
    output logic                             core_reset,
    output logic      [PCW-1:0]              fetch_addr,
    output logic                             fetch_strobe,
    output logic                             dummy_cycle,
    output logic                             vector_taken,
    output logic                             osc_drv_en,
    // Interrupt
    output logic                             irq
);
    import swc_pkg::*;

    // Pin synchronisation
    logic [1:0] pins_lvl;

    swc_sync3 #(
        .W       (2),
        .RST_VAL (2'b01)
    ) u_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .pin_in   ({edge_irq_pin, external_reset_pin_n}),
        .lvl_out  (pins_lvl)
    );

    logic rst_pin_low;
    logic edge_lvl;
    assign rst_pin_low = ~pins_lvl[0];
    assign edge_lvl    = pins_lvl[1];

    // Registers
    swc_state_t            state_q;
    swc_state_t            state_d;
    logic [CTRL_W-1:0]     ctrl_q;
    logic [NSRC-1:0]       flags_q;
    logic [NEV-1:0]        int_stat_q;
    logic [NEV-1:0]        int_stat_d;
    logic [NEV-1:0]        int_mask_q;
    logic                  to_n_q;
    logic                  slp_n_q;
    logic                  edge_prev_q;
    logic [WDT_W-1:0]      wdt_cnt_q;
    logic [OST_W-1:0]      ost_cnt_q;
    logic [1:0]            dmy_cnt_q;
    logic                  wait_q;
    logic [DATA_W-1:0]     rdata_q;
    logic                  core_hold_q;
    logic                  core_reset_q;
    logic [PCW-1:0]        fetch_addr_q;
    logic                  fetch_strobe_q;
    logic                  dummy_q;
    logic                  vector_q;
    logic                  osc_q;
    logic                  irq_q;

    // Decoded conditions
    logic            req;
    logic            wr_commit;
    logic            rd_commit;
    logic            in_sleep;
    logic            pend;
    logic            wdt_exp;
    logic            wake_rst;
    logic            wake_wdt;
    logic            wake_irq;
    logic            wake_any;
    logic            wdt_reset;
    logic            sleep_go;
    logic            edge_evt;
    logic [NSRC-1:0] flag_set;
    logic [NSRC-1:0] flag_clr;
    logic [NEV-1:0]  ev;
    logic [NEV-1:0]  stat_clr;
    logic            last_dummy;

    function automatic logic sel(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
        sel = (a == r);
    endfunction

    assign req       = avs_read | avs_write;
    assign wr_commit = avs_write & ~wait_q;
    assign rd_commit = avs_read & ~wait_q;

    assign in_sleep = (state_q == ST_ENTRY) | (state_q == ST_SLEEP);
    assign sleep_go = (state_q == ST_RUN) & sleep_exec & ~rst_pin_low;
    assign pend     = |(flags_q & ctrl_q[CTRL_EN_LSB +: NSRC]);
    assign wdt_exp  = ctrl_q[CTRL_WDT_EN] & (wdt_cnt_q == WDT_W'(WDT_CYCLES - 1));

    assign wake_rst  = in_sleep & rst_pin_low;
    assign wake_wdt  = (state_q == ST_SLEEP) & wdt_exp & ~rst_pin_low;
    // Pending at entry wakes at once, mask ignored
    assign wake_irq  = in_sleep & pend & ~rst_pin_low & ~wake_wdt;
    assign wake_any  = wake_rst | wake_wdt | wake_irq;
    assign wdt_reset = ~in_sleep & wdt_exp;
    assign last_dummy = (state_q == ST_DUMMY) & (dmy_cnt_q == 2'(DUMMY_CYCLES - 1));

    // Next state
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_RUN: begin
                if (sleep_go) begin
                    state_d = ST_ENTRY;
                end
            end
            ST_ENTRY, ST_SLEEP: begin
                if (wake_wdt || wake_irq) begin
                    state_d = ctrl_q[CTRL_RC_MODE] ? ST_RESUME : ST_OST;
                end else if (state_q == ST_ENTRY) begin
                    state_d = ST_SLEEP;
                end
            end
            ST_OST: begin
                if (ost_cnt_q == '0) begin
                    state_d = ST_RESUME;
                end
            end
            ST_RESUME: begin
                state_d = ctrl_q[CTRL_GIM] ? ST_DUMMY : ST_RUN;
            end
            ST_DUMMY: begin
                if (last_dummy) begin
                    state_d = ST_RUN;
                end
            end
        endcase
        // Reset pin or watchdog reset restarts the core, even mid start-up
        if (rst_pin_low || wdt_reset) begin
            state_d = ST_RUN;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    // Oscillator start-up and dummy counters
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ost_cnt_q <= '0;
            dmy_cnt_q <= '0;
        end else begin
            if (state_d == ST_OST && state_q != ST_OST) begin
                ost_cnt_q <= OST_W'(OST_CYCLES - 1);
            end else if (state_q == ST_OST) begin
                ost_cnt_q <= ost_cnt_q - 1'b1;
            end
            if (state_q == ST_DUMMY) begin
                dmy_cnt_q <= dmy_cnt_q + 1'b1;
            end else begin
                dmy_cnt_q <= '0;
            end
        end
    end

    // Watchdog counter, runs on through power-down
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wdt_cnt_q <= '0;
        end else if (!ctrl_q[CTRL_WDT_EN] || clrwdt || wdt_reset) begin
            wdt_cnt_q <= '0;
        end else if (sleep_go) begin
            wdt_cnt_q <= '0;
        end else if (wake_any) begin
            wdt_cnt_q <= '0;
        end else begin
            wdt_cnt_q <= wdt_cnt_q + 1'b1;
        end
    end

    // Cause flags, both active low; only power-up sets the sleep flag
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            slp_n_q <= 1'b1;
            to_n_q <= 1'b1;
        end else begin
            if (sleep_go) begin
                slp_n_q <= 1'b0;
            end
            if (wake_wdt || wdt_reset) begin
                to_n_q <= 1'b0;
            end else if (sleep_go) begin
                to_n_q <= 1'b1;
            end
        end
    end

    // Interrupt source flags, set beats software clear
    assign edge_evt = ctrl_q[CTRL_EDGE_RISE] ? (edge_lvl & ~edge_prev_q)
                                             : (~edge_lvl & edge_prev_q);
    always_comb begin
        flag_set           = '0;
        flag_set[SRC_EDGE] = edge_evt;
        flag_set[SRC_PORT] = port_change;
        flag_set[SRC_CMP]  = comparator_irq;
        flag_clr           = '0;
        if (wr_commit && sel(avs_address, REG_FLAGS)) begin
            flag_clr = avs_writedata[NSRC-1:0];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            edge_prev_q <= 1'b0;
            flags_q     <= '0;
        end else begin
            edge_prev_q <= edge_lvl;
            flags_q     <= (flags_q & ~flag_clr) | flag_set;
        end
    end

    // Core control outputs
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            core_hold_q    <= 1'b0;
            core_reset_q   <= 1'b0;
            dummy_q        <= 1'b0;
            osc_q          <= 1'b1;
        end else begin
            core_hold_q  <= (state_d != ST_RUN) && (state_d != ST_RESUME);
            core_reset_q <= rst_pin_low | wdt_reset;
            dummy_q      <= (state_d == ST_DUMMY);
            if (sleep_go) begin
                osc_q <= 1'b0;
            end else if (wake_any) begin
                osc_q <= 1'b1;
            end
        end
    end

    // Prefetch at entry, vector fetch in the cycle after the last flush cycle
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fetch_addr_q   <= '0;
            fetch_strobe_q <= 1'b0;
            vector_q       <= 1'b0;
        end else begin
            fetch_strobe_q <= 1'b0;
            vector_q       <= 1'b0;
            if (sleep_go) begin
                fetch_addr_q   <= cur_pc + 1'b1;
                fetch_strobe_q <= 1'b1;
            end else if (last_dummy && !rst_pin_low) begin
                fetch_addr_q   <= PCW'(VECTOR_ADDR);
                fetch_strobe_q <= 1'b1;
                vector_q       <= 1'b1;
            end
        end
    end

    // Sticky events, cleared by reading them; new events win
    always_comb begin
        ev               = '0;
        ev[EV_RST_WAKE]  = wake_rst;
        ev[EV_WDT_WAKE]  = wake_wdt;
        ev[EV_IRQ_WAKE]  = wake_irq;
        ev[EV_WDT_RESET] = wdt_reset;
        stat_clr         = '0;
        if (rd_commit && sel(avs_address, REG_INT_STAT)) begin
            // Only bits already returned are cleared
            stat_clr = rdata_q[NEV-1:0];
        end
        int_stat_d = (int_stat_q & ~stat_clr) | ev;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            int_stat_q <= '0;
            irq_q      <= 1'b0;
        end else begin
            int_stat_q <= int_stat_d;
            irq_q      <= |(int_stat_d & int_mask_q);
        end
    end

    // Writable registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q     <= CTRL_RST;
            int_mask_q <= '0;
        end else if (wr_commit) begin
            if (sel(avs_address, REG_CTRL)) begin
                ctrl_q <= avs_writedata[CTRL_W-1:0];
            end
            if (sel(avs_address, REG_INT_MASK)) begin
                int_mask_q <= avs_writedata[NEV-1:0];
            end
        end
    end

    // Bus handshake: one wait cycle, data captured as wait drops
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_q  <= 1'b1;
            rdata_q <= '0;
        end else if (req && wait_q) begin
            wait_q  <= 1'b0;
            rdata_q <= '0;
            if (avs_read) begin
                unique case (1'b1)
                    sel(avs_address, REG_CTRL): begin
                        rdata_q[CTRL_W-1:0] <= ctrl_q;
                    end
                    sel(avs_address, REG_STATUS): begin
                        rdata_q[ST_TO_N]                     <= to_n_q;
                        rdata_q[ST_SLP_N]                    <= slp_n_q;
                        rdata_q[ST_ASLEEP]                   <= in_sleep;
                        rdata_q[ST_STATE_LSB +: NSTATE]      <= state_q;
                    end
                    sel(avs_address, REG_FLAGS): begin
                        rdata_q[NSRC-1:0] <= flags_q;
                    end
                    sel(avs_address, REG_INT_STAT): begin
                        rdata_q[NEV-1:0] <= int_stat_q;
                    end
                    sel(avs_address, REG_INT_MASK): begin
                        rdata_q[NEV-1:0] <= int_mask_q;
                    end
                    default: begin
                        rdata_q <= '0;
                    end
                endcase
            end
        end else begin
            wait_q <= 1'b1;
        end
    end

    assign avs_readdata    = rdata_q;
    assign avs_waitrequest = wait_q;
    assign core_hold       = core_hold_q;
    assign core_reset      = core_reset_q;
    assign fetch_addr      = fetch_addr_q;
    assign fetch_strobe    = fetch_strobe_q;
    assign dummy_cycle     = dummy_q;
    assign vector_taken    = vector_q;
    assign osc_drv_en      = osc_q;
    assign irq             = irq_q;

endmodule

// file: inc/swc_pkg.sv
// Constants, register map and state encoding for the sleep/wake-up controller
// Notes on behaviour
// - Reset pin wakes the device from power-down and is handled as a full reset.
// - A reset-pin wake restarts the core from reset instead of resuming.
// - Watchdog expiry wakes from power-down only while the watchdog is enabled.
// - Edge pin, port change or comparator interrupt wakes from power-down.
// - Watchdog and interrupt wakes resume the program, no reset.
// - Sleep-entered flag is set at power-up and cleared by each power-down.
// - Watchdog-expiry flag is cleared when a watchdog expiry wakes the device.
// - The instruction at the next address is prefetched during power-down entry.
// - An interrupt source wakes only when its own enable bit is set.
// - Interrupt wake ignores the global mask; with it clear, resume in line.
// - With the global mask set, run the next instruction, then vector to 0004h.
// - Enabled pending flag at power-down entry wakes immediately, mask regardless.
// - An immediate wake still applies every side effect of power-down entry.
// - The watchdog counter is cleared on every wake, whatever the source.
// - Crystal modes wait 1024 oscillator periods after wake; RC mode skips it.
// - Power-down entry clears watchdog, clears sleep flag, sets expiry flag, stops osc.
// - Watchdog expiry wakes from power-down, but resets the device otherwise.
package swc_pkg;

    // Bus
    localparam int ADDR_W = 5;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] REG_CTRL     = 5'h00;
    localparam logic [ADDR_W-1:0] REG_STATUS   = 5'h04;
    localparam logic [ADDR_W-1:0] REG_FLAGS    = 5'h08;
    localparam logic [ADDR_W-1:0] REG_INT_STAT = 5'h0C;
    localparam logic [ADDR_W-1:0] REG_INT_MASK = 5'h10;

    // Control fields
    localparam int CTRL_WDT_EN    = 0;
    localparam int CTRL_GIM       = 1;
    localparam int CTRL_EN_LSB    = 2;
    localparam int CTRL_EDGE_RISE = 5;
    localparam int CTRL_RC_MODE   = 6;
    localparam int CTRL_W         = 7;
    localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;

    // Interrupt sources: flag and enable positions
    localparam int NSRC     = 3;
    localparam int SRC_EDGE = 0;
    localparam int SRC_PORT = 1;
    localparam int SRC_CMP  = 2;

    // Status fields
    localparam int ST_TO_N      = 0;
    localparam int ST_SLP_N     = 1;
    localparam int ST_ASLEEP    = 2;
    localparam int ST_STATE_LSB = 8;

    // Sticky event bits
    localparam int NEV          = 4;
    localparam int EV_RST_WAKE  = 0;
    localparam int EV_WDT_WAKE  = 1;
    localparam int EV_IRQ_WAKE  = 2;
    localparam int EV_WDT_RESET = 3;

    // Program counter
    localparam int PC_W = 13;
    localparam logic [PC_W-1:0] VECTOR_ADDR = 13'h0004;
    localparam int DUMMY_CYCLES = 2;

    // Timing
    localparam int CLK_NS         = 25;
    localparam int TOSC_NS        = 25;
    localparam int OST_TOSC       = 1024;
    localparam int OST_CYCLES     = (OST_TOSC * TOSC_NS + CLK_NS - 1) / CLK_NS;
    localparam int OST_W          = 11;
    localparam int WDT_MS         = 18;
    localparam int WDT_CYCLES_DEF = (WDT_MS * 1000000) / CLK_NS;
    localparam int WDT_W          = 24;

    // Sequencer states
    localparam int NSTATE = 6;
    typedef enum logic [NSTATE-1:0] {
        ST_RUN    = 6'b00_0001,
        ST_ENTRY  = 6'b00_0010,
        ST_SLEEP  = 6'b00_0100,
        ST_OST    = 6'b00_1000,
        ST_RESUME = 6'b01_0000,
        ST_DUMMY  = 6'b10_0000
    } swc_state_t;

endpackage

// file: core/swc_sync3.sv
// Three-stage pin synchroniser with agreement filter
module swc_sync3 #(
    parameter int              W       = 1,
    parameter logic [W-1:0]    RST_VAL = '0
) (
    // Clock and reset
    input  wire logic          core_clk,
    input  wire logic          rst_n,
    // Pins in, clean levels out
    input  wire logic [W-1:0]  pin_in,
    output logic      [W-1:0]  lvl_out
);

    logic [W-1:0] ff1_q;
    logic [W-1:0] ff2_q;
    logic [W-1:0] ff3_q;
    logic [W-1:0] lvl_q;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ff1_q <= RST_VAL;
            ff2_q <= RST_VAL;
            ff3_q <= RST_VAL;
        end else begin
            ff1_q <= pin_in;
            ff2_q <= ff1_q;
            ff3_q <= ff2_q;
        end
    end

    // A bit changes only once stages two and three agree
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lvl_q <= RST_VAL;
        end else begin
            lvl_q <= (ff3_q & ~(ff2_q ^ ff3_q)) | (lvl_q & (ff2_q ^ ff3_q));
        end
    end

    assign lvl_out = lvl_q;

endmodule

// file: tb/swc_sva.sv
// Port-level assertions for the sleep/wake-up controller
module swc_sva #(
    parameter int PCW = 13
) (
    // Clock and reset
    input wire logic           core_clk,
    input wire logic           rst_n,
    // Bus handshake
    input wire logic           avs_read,
    input wire logic           avs_write,
    input wire logic           avs_waitrequest,
    // Pins and core side
    input wire logic           external_reset_pin_n,
    input wire logic           sleep_exec,
    input wire logic [PCW-1:0] cur_pc,
    input wire logic           core_hold,
    input wire logic           core_reset,
    input wire logic [PCW-1:0] fetch_addr,
    input wire logic           fetch_strobe,
    input wire logic           dummy_cycle,
    input wire logic           vector_taken,
    input wire logic           osc_drv_en
);
    timeunit 1ns;
    timeprecision 1ps;
    import swc_pkg::*;
    logic [11:0] ost_q;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Start-up wait seen as held cycles with the oscillator back on
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) ost_q <= '0;
        else ost_q <= (osc_drv_en && core_hold && !dummy_cycle) ? ost_q + 12'h001 : '0;
    end
    property p_entry;
        sleep_exec && !core_hold && !core_reset |=> fetch_strobe && core_hold && !osc_drv_en
            && fetch_addr == PCW'($past(cur_pc) + 1'b1);
    endproperty
    a_entry: assert property (p_entry) else $error("bad power-down entry");
    property p_osc;
        !osc_drv_en |-> core_hold;
    endproperty
    a_osc: assert property (p_osc) else $error("core runs with oscillator off");
    property p_vec;
        vector_taken |-> fetch_strobe && fetch_addr == PCW'(4) && $past(dummy_cycle);
    endproperty
    a_vec: assert property (p_vec) else $error("bad vector fetch");
    property p_dum;
        $rose(dummy_cycle) |=> dummy_cycle ##1 (!dummy_cycle && vector_taken);
    endproperty
    a_dum: assert property (p_dum) else $error("bad flush sequence");
    property p_pin;
        $fell(external_reset_pin_n) |-> ##[3:6] core_reset;
    endproperty
    a_pin: assert property (p_pin) else $error("reset pin ignored");
    property p_rst;
        core_reset |=> !core_hold && !dummy_cycle;
    endproperty
    a_rst: assert property (p_rst) else $error("core not restarted");
    property p_ost;
        $fell(core_hold) && ost_q != 0 |-> ost_q inside {[1024:1025]};
    endproperty
    a_ost: assert property (p_ost) else $error("bad start-up wait");
    property p_bus;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest;
    endproperty
    a_bus: assert property (p_bus) else $error("bad bus answer");
    c_vec: cover property (vector_taken);
    c_ost: cover property ($fell(core_hold) && ost_q != 0);
    c_rst: cover property (core_reset);
endmodule

// file: tb/swc_partner.sv
// Reset pin and interrupt source model
module swc_partner (
    // Clock
    input  wire logic core_clk,
    // Pins and events
    output logic      external_reset_pin_n,
    output logic      edge_irq_pin,
    output logic      port_change,
    output logic      comparator_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        external_reset_pin_n = 1'b1;
        edge_irq_pin = 1'b0;
        port_change = 1'b0;
        comparator_irq = 1'b0;
    end
    // Levels held long, the pins pass a slow synchroniser
    task automatic pin(input int s, input logic v);
        @(posedge core_clk);
        if (s == 0) edge_irq_pin <= v;
        else external_reset_pin_n <= v;
        repeat (8) @(posedge core_clk);
    endtask
    task automatic pulse(input int s);
        @(posedge core_clk);
        if (s == 0) port_change <= 1'b1;
        else comparator_irq <= 1'b1;
        @(posedge core_clk);
        port_change <= 1'b0;
        comparator_irq <= 1'b0;
    endtask
endmodule

// file: tb/swc_sleep_wakeup_control_test.sv
// Self-checking bench for the sleep/wake-up controller
module swc_sleep_wakeup_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    import swc_pkg::*;
    localparam int PCW = PC_W;
    logic              core_clk = 1'b0;
    logic              rst_n = 1'b0;
    logic [ADDR_W-1:0] avs_address = '0;
    logic              avs_read = 1'b0;
    logic              avs_write = 1'b0;
    logic [DATA_W-1:0] avs_writedata = '0;
    logic [DATA_W-1:0] avs_readdata;
    logic              avs_waitrequest;
    logic              ext_n, edge_pin, port_chg, cmp_irq;
    logic              sleep_exec = 1'b0;
    logic [PCW-1:0]    cur_pc = '0;
    logic              core_hold, core_reset, fetch_strobe, dummy_cycle;
    logic              vector_taken, osc_drv_en, irq;
    logic [PCW-1:0]    fetch_addr;
    int                miscompares = 0;
    int                n_compared = 0;
    int                n;
    always #12.5 core_clk = ~core_clk;
    swc_partner u_p (.core_clk(core_clk), .external_reset_pin_n(ext_n),
        .edge_irq_pin(edge_pin), .port_change(port_chg), .comparator_irq(cmp_irq));
    // Short watchdog keeps the run brief
    swc_sleep_wakeup_control #(.WDT_CYCLES(200), .PCW(PCW)) uut (
        .core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .external_reset_pin_n(ext_n), .edge_irq_pin(edge_pin), .port_change(port_chg),
        .comparator_irq(cmp_irq), .sleep_exec(sleep_exec), .clrwdt(1'b0),
        .cur_pc(cur_pc), .core_hold(core_hold), .core_reset(core_reset),
        .fetch_addr(fetch_addr), .fetch_strobe(fetch_strobe), .dummy_cycle(dummy_cycle),
        .vector_taken(vector_taken), .osc_drv_en(osc_drv_en), .irq(irq));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic complete_run;
        $display("compared=%0d mismatches=%0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Idle edge after release so a following request never shares a time step
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        do begin
            @(posedge core_clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask
    task automatic do_sleep(input logic [12:0] pc);
        sleep_exec <= 1'b1;
        cur_pc <= pc;
        @(posedge core_clk);
        sleep_exec <= 1'b0;
        @(negedge core_clk);
        chk(32'(fetch_addr), 32'(pc + 13'h1));
        chk(32'({fetch_strobe, core_hold, osc_drv_en}), 32'h0000_0006);
        @(posedge core_clk);
    endtask
    task automatic wait_on(input int sel, output int c);
        c = 0;
        while ((sel == 0 ? core_hold !== 1'b0 : sel == 1 ? vector_taken !== 1'b1
                : core_reset !== 1'b1) && c < 3000) begin
            @(posedge core_clk);
            c++;
        end
    endtask
    task automatic t_reset;
        rd(REG_CTRL, 32'h0000_0000);
        rd(REG_STATUS, 32'h0000_0103);
        rd(5'h14, 32'h0000_0000);
        wr(REG_STATUS, 32'h0000_0000);
        rd(REG_STATUS, 32'h0000_0103);
    endtask
    task automatic t_edge;
        wr(REG_CTRL, 32'h0000_0064);
        do_sleep(13'h0100);
        rd(REG_STATUS, 32'h0000_0405);
        u_p.pulse(0);
        repeat (20) @(posedge core_clk);
        chk(32'(core_hold), 32'h0000_0001);
        u_p.pin(0, 1'b1);
        wait_on(0, n);
        chk(32'(core_hold), 32'h0000_0000);
        @(posedge core_clk);
        chk(32'({core_hold, dummy_cycle}), 32'h0000_0000);
        u_p.pin(0, 1'b0);
        rd(REG_FLAGS, 32'h0000_0003);
        wr(REG_FLAGS, 32'h0000_0003);
        rd(REG_FLAGS, 32'h0000_0000);
        rd(REG_INT_STAT, 32'h0000_0004);
    endtask
    task automatic t_vector;
        wr(REG_CTRL, 32'h0000_004A);
        u_p.pulse(0);
        do_sleep(13'h0200);
        wait_on(1, n);
        chk(32'(fetch_addr), 32'h0000_0004);
        chk(32'(n < 12), 32'h0000_0001);
        rd(REG_STATUS, 32'h0000_0101);
        rd(REG_INT_STAT, 32'h0000_0004);
        wr(REG_FLAGS, 32'h0000_0002);
    endtask
    task automatic t_ost;
        wr(REG_CTRL, 32'h0000_0010);
        do_sleep(13'h0300);
        repeat (300) @(posedge core_clk);
        chk(32'(core_hold), 32'h0000_0001);
        u_p.pulse(1);
        wait_on(0, n);
        chk(32'(n >= 1024 && n <= 1030), 32'h0000_0001);
        wr(REG_FLAGS, 32'h0000_0004);
        rd(REG_INT_STAT, 32'h0000_0004);
    endtask
    task automatic t_wdt;
        wr(REG_INT_MASK, 32'h0000_0008);
        wr(REG_CTRL, 32'h0000_0041);
        do_sleep(13'h0400);
        wait_on(0, n);
        chk(32'(n > 150 && n < 260), 32'h0000_0001);
        chk(32'(irq), 32'h0000_0000);
        rd(REG_STATUS, 32'h0000_0100);
        wait_on(2, n);
        chk(32'(n > 175 && n < 215), 32'h0000_0001);
        repeat (3) @(posedge core_clk);
        chk(32'(irq), 32'h0000_0001);
        rd(REG_INT_STAT, 32'h0000_000A);
        wr(REG_CTRL, 32'h0000_0000);
        chk(32'(irq), 32'h0000_0000);
        wr(REG_INT_MASK, 32'h0000_0000);
    endtask
    task automatic t_pin;
        wr(REG_CTRL, 32'h0000_0040);
        do_sleep(13'h0500);
        u_p.pin(1, 1'b0);
        chk(32'({core_reset, core_hold}), 32'h0000_0002);
        u_p.pin(1, 1'b1);
        rd(REG_INT_STAT, 32'h0000_0001);
    endtask
    initial begin
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        t_reset;
        t_edge;
        t_vector;
        t_ost;
        t_wdt;
        t_pin;
        complete_run;
    end
    initial begin
        #250000;
        miscompares++;
        complete_run;
    end
endmodule
bind swc_sleep_wakeup_control swc_sva #(.PCW(PCW)) u_sva (
    .core_clk(core_clk), .rst_n(rst_n), .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .external_reset_pin_n(external_reset_pin_n),
    .sleep_exec(sleep_exec), .cur_pc(cur_pc), .core_hold(core_hold),
    .core_reset(core_reset), .fetch_addr(fetch_addr), .fetch_strobe(fetch_strobe),
    .dummy_cycle(dummy_cycle), .vector_taken(vector_taken), .osc_drv_en(osc_drv_en));
